// ### hw/ivm_defs.vh
// register offsets, field positions, reset values and vector addresses of the vector map
`ifndef IVM_DEFS_VH
`define IVM_DEFS_VH

// control and status registers, byte addresses on the register bus
`define IVM_CTRL_OFF 18'h00000
`define IVM_SRC_EN_OFF 18'h00004
`define IVM_PEND_OFF 18'h00008
`define IVM_ACTIVE_OFF 18'h0000C
`define IVM_INT_STAT_OFF 18'h00010
`define IVM_INT_EN_OFF 18'h00014
`define IVM_INT_CLR_OFF 18'h00018
`define IVM_WDOG_CNT_OFF 18'h0001C

// control register fields, reset values of the control and source enable registers
`define IVM_CTRL_WDOG_EN 0
`define IVM_CTRL_RST 32'h00000001
`define IVM_SRC_EN_RST 16'hFFFF

// event bits of the interrupt status register
`define IVM_EV_WDOG_TIMEOUT 0
`define IVM_EV_VEC_TAKEN 1
`define IVM_EV_SERVICE_WR 2
`define IVM_EV_W 3

// vector table index range; the bus byte address is four times the index
`define IVM_VEC_FIRST 16'hFFDC
`define IVM_VEC_LAST 16'hFFFF
`define IVM_VEC_BYTES 36
`define IVM_VEC_ERASED 8'hFF

// vector pair addresses, high byte at the even address
`define IVM_VEC_RESET 16'hFFFE
`define IVM_VEC_SWTRAP 16'hFFFC
`define IVM_VEC_EXTPIN 16'hFFFA
`define IVM_VEC_CLKMON 16'hFFF8
`define IVM_VEC_T1_CH0 16'hFFF6
`define IVM_VEC_T1_CH1 16'hFFF4
`define IVM_VEC_T1_OVF 16'hFFF2
`define IVM_VEC_T2_CH0 16'hFFF0
`define IVM_VEC_T2_CH1 16'hFFEE
`define IVM_VEC_T2_OVF 16'hFFEC
`define IVM_VEC_SER_ERR 16'hFFEA
`define IVM_VEC_SER_RX 16'hFFE8
`define IVM_VEC_SER_TX 16'hFFE6
`define IVM_VEC_KEYPAD 16'hFFE4
`define IVM_VEC_CONV 16'hFFE2
`define IVM_VEC_SPI_RX 16'hFFE0
`define IVM_VEC_SPI_TX 16'hFFDE
`define IVM_VEC_TIMEBASE 16'hFFDC

// watchdog period in clock cycles
`define IVM_WDOG_CYCLES 262144

// bus responses
`define IVM_RESP_OKAY 2'h0
`define IVM_RESP_SLVERR 2'h2

`endif

// ### hw/ivm_prio.v
// fixed priority encoder: the lowest set request index wins
module ivm_prio #(
  parameter N = 18,
  parameter IW = 5
) (
  input wire [N-1:0] req,
  output wire found,
  output wire [IW-1:0] idx
);
  wire [N:0] seen;
  wire [IW*(N+1)-1:0] acc;

  assign seen[0] = 1'b0;
  assign acc[IW-1:0] = {IW{1'b0}};

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_ent
      localparam integer KI = i;
      localparam [IW-1:0] K = KI[IW-1:0];
      wire grant;
      assign grant = req[i] & ~seen[i];
      assign seen[i+1] = seen[i] | req[i];
      assign acc[IW*(i+1) +: IW] = acc[IW*i +: IW] | (grant ? K : {IW{1'b0}});
    end
  endgenerate

  assign found = seen[N];
  assign idx = acc[IW*N +: IW];
endmodule

// ### hw/ivm_top.v
// interrupt vector map: vector table, source priority, vector fetch and watchdog service
`include "ivm_defs.vh"

module ivm_top #(
  parameter WDOG_CYCLES = `IVM_WDOG_CYCLES,
  parameter WDOG_W = 20
) (
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire [17:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [17:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // processor core memory port
  input wire core_rd,
  input wire core_wr,
  input wire [15:0] core_addr,
  input wire [7:0] core_wdata,
  output wire [7:0] core_rdata,
  // interrupt sources: bit k is pending flag k+1, bit 0 the external pin, bit 15 timebase
  input wire [15:0] src_pending,
  input wire software_trap_instruction,
  // selected vector
  output wire vec_valid,
  output wire [4:0] vec_rank,
  output wire [15:0] vec_addr,
  output wire [15:0] vec_data,
  // watchdog and interrupt
  output wire watchdog_counter_timeout,
  output wire irq
);
  localparam NSRC = 18;
  localparam [WDOG_W-1:0] WDOG_LAST = WDOG_CYCLES[WDOG_W-1:0] - 1'b1;

  // bus slave state
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [17:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  // software registers
  reg [31:0] ctrl_q;
  reg [15:0] src_en_q;
  reg [`IVM_EV_W-1:0] stat_q;
  reg [`IVM_EV_W-1:0] int_en_q;
  reg irq_q;

  // vector table, fetch and watchdog
  reg [7:0] tbl_q [0:`IVM_VEC_BYTES-1];
  reg reset_pend_q;
  reg [7:0] core_rdata_q;
  reg vec_valid_q;
  reg [4:0] vec_rank_q;
  reg [15:0] vec_addr_q;
  reg [15:0] vec_data_q;
  reg [WDOG_W-1:0] wdog_cnt_q;
  reg wdog_to_q;

  wire wr_fire;
  wire [31:0] wmask;
  wire [15:0] wr_index;
  wire wr_tbl;
  wire [15:0] wr_off;
  wire [15:0] rd_index;
  wire [15:0] rd_off;
  wire rd_tbl;
  wire [15:0] core_off;
  wire core_tbl;
  wire service_wr;
  wire [NSRC-1:0] req_all;
  wire sel_found;
  wire [4:0] sel_rank;
  reg [15:0] sel_addr;
  wire [15:0] sel_off;
  reg [31:0] rd_data;
  reg rd_err;
  wire [`IVM_EV_W-1:0] events;
  wire [`IVM_EV_W-1:0] clr_bits;
  wire [`IVM_EV_W-1:0] stat_d;
  wire vec_taken;

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign core_rdata = core_rdata_q;
  assign vec_valid = vec_valid_q;
  assign vec_rank = vec_rank_q;
  assign vec_addr = vec_addr_q;
  assign vec_data = vec_data_q;
  assign watchdog_counter_timeout = wdog_to_q;
  assign irq = irq_q;

  // write channel: address and data are taken in either order, the response follows both
  assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_index = awaddr_q[17:2];
  assign wr_tbl = (wr_index >= `IVM_VEC_FIRST);
  assign wr_off = wr_index - `IVM_VEC_FIRST;

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 18'h00000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `IVM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q <= s_axi_awaddr;
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        case (awaddr_q)
          `IVM_CTRL_OFF, `IVM_SRC_EN_OFF, `IVM_INT_EN_OFF, `IVM_INT_CLR_OFF:
            bresp_q <= `IVM_RESP_OKAY;
          default:
            bresp_q <= wr_tbl ? `IVM_RESP_OKAY : `IVM_RESP_SLVERR;
        endcase
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // software registers
  assign clr_bits = (wr_fire && awaddr_q == `IVM_INT_CLR_OFF) ?
                    (wdata_q[`IVM_EV_W-1:0] & wmask[`IVM_EV_W-1:0]) : {`IVM_EV_W{1'b0}};
  // a new event wins over a clear in the same cycle
  assign stat_d = (stat_q & ~clr_bits) | events;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `IVM_CTRL_RST;
      src_en_q <= `IVM_SRC_EN_RST;
      int_en_q <= {`IVM_EV_W{1'b0}};
      stat_q <= {`IVM_EV_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      if (wr_fire && awaddr_q == `IVM_CTRL_OFF) begin
        ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
      end
      if (wr_fire && awaddr_q == `IVM_SRC_EN_OFF) begin
        src_en_q <= (src_en_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
      end
      if (wr_fire && awaddr_q == `IVM_INT_EN_OFF) begin
        int_en_q <= (int_en_q & ~wmask[`IVM_EV_W-1:0]) |
                    (wdata_q[`IVM_EV_W-1:0] & wmask[`IVM_EV_W-1:0]);
      end
      stat_q <= stat_d;
      irq_q <= |(stat_d & int_en_q);
    end
  end

  // read channel: data one cycle after the address is taken
  assign rd_index = s_axi_araddr[17:2];
  assign rd_tbl = (rd_index >= `IVM_VEC_FIRST);
  assign rd_off = rd_index - `IVM_VEC_FIRST;

  always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `IVM_CTRL_OFF: rd_data = ctrl_q;
      `IVM_SRC_EN_OFF: rd_data = {16'h0000, src_en_q};
      `IVM_PEND_OFF: rd_data = {14'h0000, req_all};
      `IVM_ACTIVE_OFF: rd_data = {vec_valid_q, 2'h0, vec_rank_q, 8'h00, vec_data_q};
      `IVM_INT_STAT_OFF: rd_data = {29'h00000000, stat_q};
      `IVM_INT_EN_OFF: rd_data = {29'h00000000, int_en_q};
      `IVM_INT_CLR_OFF: rd_data = 32'h00000000;
      `IVM_WDOG_CNT_OFF: rd_data = {{(32-WDOG_W){1'b0}}, wdog_cnt_q};
      default: begin
        if (rd_tbl && s_axi_araddr[1:0] == 2'h0) begin
          rd_data = {24'h000000, tbl_q[rd_off[5:0]]};
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `IVM_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_data;
        rresp_q <= rd_err ? `IVM_RESP_SLVERR : `IVM_RESP_OKAY;
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // vector table bytes, one per entry, programmed from the register bus
  genvar g;
  generate
    for (g = 0; g < `IVM_VEC_BYTES; g = g + 1) begin : g_tbl
      always @(posedge aclk) begin
        if (!aresetn) begin
          tbl_q[g] <= `IVM_VEC_ERASED;
        end else if (wr_fire && wr_tbl && wr_off[5:0] == g && wstrb_q[0]) begin
          tbl_q[g] <= wdata_q[7:0];
        end
      end
    end
  endgenerate

  // core port: table reads, service location writes
  assign core_off = core_addr - `IVM_VEC_FIRST;
  assign core_tbl = (core_addr >= `IVM_VEC_FIRST);
  assign service_wr = core_wr && core_addr == `IVM_VEC_LAST;
  assign vec_taken = core_rd && vec_valid_q && core_addr == (vec_addr_q + 16'h0001);

  always @(posedge aclk) begin
    if (!aresetn) begin
      core_rdata_q <= 8'h00;
    end else if (core_rd && core_tbl) begin
      // the service location reads back the reset vector low byte
      core_rdata_q <= tbl_q[core_off[5:0]];
    end else begin
      core_rdata_q <= 8'h00;
    end
  end

  // reset vector stays pending until the core fetches its low byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      reset_pend_q <= 1'b1;
    end else if (core_rd && core_addr == `IVM_VEC_LAST) begin
      reset_pend_q <= 1'b0;
    end
  end

  // rank 0 is reset, 1 the software trap, rank k+2 pending flag k+1
  assign req_all = {src_pending & src_en_q, software_trap_instruction, reset_pend_q};

  ivm_prio #(
    .N(NSRC),
    .IW(5)
  ) u_prio (
    .req(req_all),
    .found(sel_found),
    .idx(sel_rank)
  );

  always @* begin
    case (sel_rank)
      5'h00: sel_addr = `IVM_VEC_RESET;
      5'h01: sel_addr = `IVM_VEC_SWTRAP;
      5'h02: sel_addr = `IVM_VEC_EXTPIN;
      5'h03: sel_addr = `IVM_VEC_CLKMON;
      5'h04: sel_addr = `IVM_VEC_T1_CH0;
      5'h05: sel_addr = `IVM_VEC_T1_CH1;
      5'h06: sel_addr = `IVM_VEC_T1_OVF;
      5'h07: sel_addr = `IVM_VEC_T2_CH0;
      5'h08: sel_addr = `IVM_VEC_T2_CH1;
      5'h09: sel_addr = `IVM_VEC_T2_OVF;
      5'h0A: sel_addr = `IVM_VEC_SER_ERR;
      5'h0B: sel_addr = `IVM_VEC_SER_RX;
      5'h0C: sel_addr = `IVM_VEC_SER_TX;
      5'h0D: sel_addr = `IVM_VEC_KEYPAD;
      5'h0E: sel_addr = `IVM_VEC_CONV;
      5'h0F: sel_addr = `IVM_VEC_SPI_RX;
      5'h10: sel_addr = `IVM_VEC_SPI_TX;
      5'h11: sel_addr = `IVM_VEC_TIMEBASE;
      default: sel_addr = `IVM_VEC_RESET;
    endcase
  end

  assign sel_off = sel_addr - `IVM_VEC_FIRST;

  always @(posedge aclk) begin
    if (!aresetn) begin
      vec_valid_q <= 1'b0;
      vec_rank_q <= 5'h00;
      vec_addr_q <= `IVM_VEC_RESET;
      vec_data_q <= 16'h0000;
    end else begin
      vec_valid_q <= sel_found;
      vec_rank_q <= sel_rank;
      vec_addr_q <= sel_addr;
      // high byte from the even address, low byte from the next
      vec_data_q <= {tbl_q[sel_off[5:0]], tbl_q[sel_off[5:0] + 6'h01]};
    end
  end

  // watchdog: restarts on any value written to the service location
  always @(posedge aclk) begin
    if (!aresetn) begin
      wdog_cnt_q <= {WDOG_W{1'b0}};
      wdog_to_q <= 1'b0;
    end else if (service_wr || !ctrl_q[`IVM_CTRL_WDOG_EN]) begin
      wdog_cnt_q <= {WDOG_W{1'b0}};
      wdog_to_q <= 1'b0;
    end else if (wdog_cnt_q == WDOG_LAST) begin
      wdog_cnt_q <= {WDOG_W{1'b0}};
      wdog_to_q <= 1'b1;
    end else begin
      wdog_cnt_q <= wdog_cnt_q + {{(WDOG_W-1){1'b0}}, 1'b1};
      wdog_to_q <= 1'b0;
    end
  end

  assign events = {service_wr, vec_taken, wdog_to_q};
endmodule

// ### tb/ivm_props.sv
// checker of vector selection, watchdog service and bus answers
module ivm_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire core_wr,
  input wire [15:0] core_addr,
  input wire [15:0] src_pending,
  input wire software_trap_instruction,
  input wire vec_valid,
  input wire [4:0] vec_rank,
  input wire [15:0] vec_addr,
  input wire watchdog_counter_timeout
);
  logic [15:0] pend_q;
  logic trap_q;
  always @(posedge aclk) begin
    pend_q <= src_pending;
    trap_q <= software_trap_instruction;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_map;
    vec_valid |-> vec_addr == 16'hFFFE - {10'h000, vec_rank, 1'b0};
  endproperty
  a_map: assert property (p_map) else $error("vector address off its rank");
  property p_prio;
    (vec_valid && vec_rank > 5'h01) |-> !trap_q && pend_q[vec_rank - 5'h02] &&
      ((pend_q & ((16'h0001 << (vec_rank - 5'h02)) - 16'h0001)) == 16'h0000);
  endproperty
  a_prio: assert property (p_prio) else $error("selected source not the highest");
  property p_ext;
    src_pending[0] |=> vec_valid && vec_rank <= 5'h02;
  endproperty
  a_ext: assert property (p_ext) else $error("external pin outranked");
  property p_trap;
    software_trap_instruction |=> vec_valid && vec_rank <= 5'h01;
  endproperty
  a_trap: assert property (p_trap) else $error("software trap outranked");
  property p_svc;
    core_wr && core_addr == 16'hFFFF |=> !watchdog_counter_timeout [*8];
  endproperty
  a_svc: assert property (p_svc) else $error("timeout right after service");
  property p_pulse;
    watchdog_counter_timeout |=> !watchdog_counter_timeout;
  endproperty
  a_pulse: assert property (p_pulse) else $error("timeout longer than a pulse");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule

bind ivm_top ivm_props props_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .core_wr(core_wr),
  .core_addr(core_addr), .src_pending(src_pending),
  .software_trap_instruction(software_trap_instruction), .vec_valid(vec_valid),
  .vec_rank(vec_rank), .vec_addr(vec_addr), .watchdog_counter_timeout(watchdog_counter_timeout));

// ### tb/ivm_core_model.sv
// processor core model: fetches vector pairs and writes the service location
module ivm_core_model (
  input wire aclk,
  input wire [7:0] core_rdata,
  output logic core_rd,
  output logic core_wr,
  output logic [15:0] core_addr,
  output logic [7:0] core_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    core_rd = 1'b0;
    core_wr = 1'b0;
    core_addr = 16'h0000;
    core_wdata = 8'h00;
  end
  // high byte at the even address, low byte next; address inverted when idle
  task automatic fetch(input logic [15:0] a, output logic [15:0] v);
    core_rd <= 1'b1;
    core_addr <= a;
    @(posedge aclk);
    core_addr <= a + 16'h0001;
    @(posedge aclk);
    v[15:8] = core_rdata;
    core_rd <= 1'b0;
    core_addr <= ~a;
    @(posedge aclk);
    v[7:0] = core_rdata;
  endtask
  task automatic service;
    core_wr <= 1'b1;
    core_addr <= 16'hFFFF;
    core_wdata <= 8'hA5;
    @(posedge aclk);
    core_wr <= 1'b0;
    core_addr <= 16'h0000;
    core_wdata <= 8'h5A;
  endtask
endmodule

// ### tb/testbench.sv
// self-checking bench of the interrupt vector map
`include "ivm_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WDC = 64;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trap;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [15:0] src;
  wire awready, wready, bvalid, arready, rvalid, core_rd, core_wr, vv, wto, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] core_addr, va, vd;
  wire [7:0] core_wdata, core_rdata;
  wire [4:0] vr;
  int n_fail, n_tests, n_to;
  ivm_top #(.WDOG_CYCLES(WDC)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_rd(core_rd), .core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata),
    .core_rdata(core_rdata), .src_pending(src), .software_trap_instruction(trap),
    .vec_valid(vv), .vec_rank(vr), .vec_addr(va), .vec_data(vd),
    .watchdog_counter_timeout(wto), .irq(irq));
  ivm_core_model core_u (.aclk(aclk), .core_rdata(core_rdata), .core_rd(core_rd),
    .core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (wto) n_to <= n_to + 1;
  function automatic logic [7:0] vb(input logic [15:0] a);
    vb = a[7:0] ^ 8'h3C;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // let an edge pass so the next call never re-raises bready in this step
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic t_table;
    logic [1:0] r;
    logic [31:0] d;
    for (int k = 0; k < 36; k++) begin
      axi_wr({16'hFFDC + k[15:0], 2'b00}, {24'h0, vb(16'hFFDC + k[15:0])}, r);
      chk("table write", `IVM_RESP_OKAY, r);
    end
    axi_wr(18'h00100, 32'h1, r);
    chk("unmapped write", `IVM_RESP_SLVERR, r);
    axi_rd(18'h00100, d, r);
    chk("unmapped read", `IVM_RESP_SLVERR, r);
    chk("unmapped data", 32'h00000000, d);
    axi_rd({`IVM_VEC_KEYPAD, 2'b00}, d, r);
    chk("table read", vb(`IVM_VEC_KEYPAD), d);
    $display("table test done");
  endtask
  task automatic t_prio;
    logic [15:0] v, ea;
    core_u.fetch(`IVM_VEC_RESET, v);
    chk("reset vector", {vb(16'hFFFE), vb(16'hFFFF)}, v);
    for (int r = 2; r < 18; r++) begin
      src <= 16'hFFFF << (r - 2);
      ea = 16'hFFFE - r[15:0] * 16'h0002;
      repeat (2) @(posedge aclk);
      chk("rank", r, vr);
      chk("vector addr", ea, va);
      chk("vector data", {vb(ea), vb(ea + 16'h0001)}, vd);
      core_u.fetch(ea, v);
      chk("fetched", {vb(ea), vb(ea + 16'h0001)}, v);
    end
    src <= 16'hFFFF;
    trap <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("trap addr", `IVM_VEC_SWTRAP, va);
    trap <= 1'b0;
    src <= 16'h0000;
    $display("priority test done");
  endtask
  task automatic t_wdog;
    logic [1:0] r;
    logic [31:0] d;
    int c0, n;
    core_u.service;
    axi_wr(`IVM_INT_CLR_OFF, 32'h7, r);
    axi_wr(`IVM_INT_EN_OFF, 32'h1, r);
    c0 = n_to;
    for (int i = 0; i < 4; i++) begin
      repeat (WDC - 20) @(posedge aclk);
      core_u.service;
    end
    chk("timeouts while serviced", 0, n_to - c0);
    n = 0;
    while (n_to == c0 && n < 4 * WDC) begin
      @(posedge aclk);
      n++;
    end
    chk("timeout period", 1, n >= WDC - 3 && n <= WDC + 3);
    repeat (2) @(posedge aclk);
    chk("irq raised", 1'b1, irq);
    axi_wr(`IVM_INT_EN_OFF, 32'h0, r);
    repeat (2) @(posedge aclk);
    chk("irq masked", 1'b0, irq);
    axi_wr(`IVM_INT_EN_OFF, 32'h1, r);
    repeat (2) @(posedge aclk);
    chk("irq unmasked", 1'b1, irq);
    axi_rd(`IVM_INT_STAT_OFF, d, r);
    chk("status", 32'h00000005, d);
    axi_wr(`IVM_INT_CLR_OFF, 32'h1, r);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 1'b0, irq);
    $display("watchdog test done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    test_done;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, trap} = 7'h00;
    {awaddr, araddr, wdata, src} = 84'h0;
    {n_fail, n_tests, n_to} = {32'd0, 32'd0, 32'd0};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("reset pending", 1'b1, vv);
    chk("reset rank", 0, vr);
    t_table;
    t_prio;
    t_wdog;
    test_done;
  end
endmodule
